// ==== core/dopr_pkg.sv ====
// Constants shared by the doppler resolver design
package dopr_pkg;

    // Window and bin geometry
    localparam int DOPR_NSAMP = 16;      // Samples per integration window
    localparam int DOPR_KMAX = 4;        // Bins span -KMAX .. +KMAX
    localparam int DOPR_Q_W = 3;         // Eight-level sample quantizer
    localparam int DOPR_TW_W = 8;        // Twiddle word width
    localparam int DOPR_ACC_W = 16;      // Partial-sum accumulator width
    localparam int DOPR_SCALE_SH = 5;    // Divide by 2*NSAMP as a shift
    localparam int DOPR_SC_W = DOPR_ACC_W + 1 - DOPR_SCALE_SH;
    localparam int DOPR_PWR_W = 2 * DOPR_SC_W + 1;
    localparam int DOPR_BIN_W = 4;       // Signed bin index width
    localparam int DOPR_BUF_DEPTH = 2;   // Entries in the input buffer
    localparam int DOPR_QUARTER = DOPR_NSAMP / 4;

    // Reset values
    localparam logic [1:0] DOPR_CNT_RST = 2'h0;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        DOPR_S_IDLE = 5'h01,
        DOPR_S_FILL = 5'h02,
        DOPR_S_ACC = 5'h04,
        DOPR_S_BIN = 5'h08,
        DOPR_S_DEC = 5'h10
    } dopr_state_t;

endpackage : dopr_pkg

// ==== core/dopr_resolver.sv ====
// Real-time doppler uncertainty resolver with a small input buffer
`timescale 1ns/100ps
`default_nettype none

module dopr_resolver #(
    parameter int NSAMP = dopr_pkg::DOPR_NSAMP,
    parameter int KMAX = dopr_pkg::DOPR_KMAX
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic step_start_i,
    input wire logic smp_valid_i,
    input wire logic [dopr_pkg::DOPR_Q_W-1:0] smp_i_i,
    input wire logic [dopr_pkg::DOPR_Q_W-1:0] smp_q_i,
    output logic smp_ready_o,
    input wire logic [dopr_pkg::DOPR_PWR_W-1:0] thresh_i,
    output logic busy_o,
    output logic done_o,
    output logic detect_o,
    output logic step_req_o,
    output logic [dopr_pkg::DOPR_BIN_W-1:0] bin_o,
    output logic [dopr_pkg::DOPR_PWR_W-1:0] peak_o
);

    localparam int QW = dopr_pkg::DOPR_Q_W;
    localparam int AW = dopr_pkg::DOPR_ACC_W;
    localparam int SW = dopr_pkg::DOPR_SC_W;
    localparam int PW = dopr_pkg::DOPR_PWR_W;
    localparam int BW = dopr_pkg::DOPR_BIN_W;
    localparam int LN = $clog2(NSAMP);
    localparam int KW = $clog2(KMAX + 1);

    // The twiddle table is written for one window length only
    if (NSAMP != 16 || KMAX < 1 || KMAX >= NSAMP / 2)
    begin : g_bad_param
        $error("dopr_resolver: unsupported NSAMP or KMAX");
    end

    // Cosine of 2*pi*i/16 scaled to 127
    function automatic logic signed [7:0] cos_lut(input logic [3:0] i);
        logic signed [7:0] v;
        v = 8'h00;
        unique case (i)
            4'h0: v = 8'h7f;
            4'h1: v = 8'h75;
            4'h2: v = 8'h5a;
            4'h3: v = 8'h31;
            4'h4: v = 8'h00;
            4'h5: v = 8'hcf;
            4'h6: v = 8'ha6;
            4'h7: v = 8'h8b;
            4'h8: v = 8'h81;
            4'h9: v = 8'h8b;
            4'ha: v = 8'ha6;
            4'hb: v = 8'hcf;
            4'hc: v = 8'h00;
            4'hd: v = 8'h31;
            4'he: v = 8'h5a;
            4'hf: v = 8'h75;
        endcase
        return v;
    endfunction : cos_lut

    // Two-entry input buffer; draining stalls outside the fill phase
    logic [QW-1:0] bi_q [dopr_pkg::DOPR_BUF_DEPTH];
    logic [QW-1:0] bq_q [dopr_pkg::DOPR_BUF_DEPTH];
    logic [1:0] cnt_q, cnt_d;
    logic wp_q, wp_d, rp_q, rp_d, rdy_q, rdy_d;
    logic push, pop;
    dopr_pkg::dopr_state_t st_q, st_d;

    assign push = smp_valid_i && rdy_q;
    assign pop = (cnt_q != dopr_pkg::DOPR_CNT_RST) && (st_q == dopr_pkg::DOPR_S_FILL);

    // Pointer and fill-level bookkeeping
    always_comb
    begin
        wp_d = wp_q ^ push;
        rp_d = rp_q ^ pop;
        cnt_d = cnt_q + 2'(push) - 2'(pop);
        rdy_d = (cnt_d != 2'(dopr_pkg::DOPR_BUF_DEPTH)); // Full blocks source
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_q <= dopr_pkg::DOPR_CNT_RST;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            rdy_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            rdy_q <= rdy_d;
        end
    end

    // Buffer entries: storage only, no reset needed
    for (genvar e = 0; e < dopr_pkg::DOPR_BUF_DEPTH; e++)
    begin : g_buf
        always_ff @(posedge clk_i)
        begin
            if (push && wp_q == 1'(e))
            begin
                bi_q[e] <= smp_i_i;
                bq_q[e] <= smp_q_i;
            end
        end
    end

    // Window memory for one integration window of I and Q samples
    logic signed [QW-1:0] mi_q [NSAMP];
    logic signed [QW-1:0] mq_q [NSAMP];
    logic [LN-1:0] widx_q, widx_d;

    always_ff @(posedge clk_i)
    begin
        if (pop)
        begin
            mi_q[widx_q] <= bi_q[rp_q];
            mq_q[widx_q] <= bq_q[rp_q];
        end
    end

    // Sequencer and accumulator state
    logic [KW-1:0] k_q, k_d;
    logic [LN-1:0] m_q, m_d, ph_q, ph_d;
    logic signed [AW-1:0] icos_q, icos_d, isin_q, isin_d;
    logic signed [AW-1:0] qcos_q, qcos_d, qsin_q, qsin_d;
    logic [PW-1:0] best_q, best_d, peak_q, peak_d;
    logic signed [BW-1:0] bbin_q, bbin_d, bin_q, bin_d;
    logic det_q, det_d, stp_q, stp_d, done_q, done_d, busy_q, busy_d;
    logic signed [7:0] cw, sw;
    logic signed [AW:0] a_raw, bp_raw, bm_raw;
    logic signed [SW-1:0] a_s, bp_s, bm_s;
    logic [PW-1:0] pp, pm;

    // Twiddles; sine is cosine a quarter turn back
    assign cw = cos_lut(4'(ph_q));
    assign sw = cos_lut(4'(ph_q - LN'(dopr_pkg::DOPR_QUARTER)));

    // Coefficients shared by bins +k and -k, scaled by 1/(2RT)
    always_comb
    begin
        a_raw = (AW+1)'(icos_q) + (AW+1)'(qsin_q);
        bp_raw = (AW+1)'(qcos_q) + (AW+1)'(isin_q);
        bm_raw = (AW+1)'(qcos_q) - (AW+1)'(isin_q);
        a_s = SW'(a_raw >>> dopr_pkg::DOPR_SCALE_SH);
        bp_s = SW'(bp_raw >>> dopr_pkg::DOPR_SCALE_SH);
        bm_s = SW'(bm_raw >>> dopr_pkg::DOPR_SCALE_SH);
        // Widen before squaring so the product keeps every bit
        pp = unsigned'(PW'(a_s) * PW'(a_s) + PW'(bp_s) * PW'(bp_s));
        pm = unsigned'(PW'(a_s) * PW'(a_s) + PW'(bm_s) * PW'(bm_s));
    end

    // Next-state logic: fill window, sweep bins, decide
    always_comb
    begin
        st_d = st_q;
        widx_d = widx_q;
        k_d = k_q;
        m_d = m_q;
        ph_d = ph_q;
        icos_d = icos_q;
        isin_d = isin_q;
        qcos_d = qcos_q;
        qsin_d = qsin_q;
        best_d = best_q;
        bbin_d = bbin_q;
        det_d = det_q;
        stp_d = 1'b0;
        done_d = 1'b0;
        peak_d = peak_q;
        bin_d = bin_q;
        busy_d = busy_q;
        unique case (st_q)
            dopr_pkg::DOPR_S_IDLE:
            begin
                if (step_start_i)
                begin
                    st_d = dopr_pkg::DOPR_S_FILL;
                    widx_d = '0;
                    best_d = '0;
                    bbin_d = '0;
                    det_d = 1'b0;
                    busy_d = 1'b1;
                end
            end
            dopr_pkg::DOPR_S_FILL:
            begin
                if (pop)
                begin
                    widx_d = widx_q + 1'b1;
                    if (widx_q == LN'(NSAMP - 1))
                    begin
                        st_d = dopr_pkg::DOPR_S_ACC;
                        k_d = '0;
                        m_d = '0;
                        ph_d = '0;
                        icos_d = '0;
                        isin_d = '0;
                        qcos_d = '0;
                        qsin_d = '0;
                    end
                end
            end
            dopr_pkg::DOPR_S_ACC:
            begin
                // One sample per cycle; phase steps by k for m = 1..RT
                icos_d = icos_q + AW'(mi_q[m_q]) * AW'(cw);
                qsin_d = qsin_q + AW'(mq_q[m_q]) * AW'(sw);
                qcos_d = qcos_q + AW'(mq_q[m_q]) * AW'(cw);
                isin_d = isin_q + AW'(mi_q[m_q]) * AW'(sw);
                m_d = m_q + 1'b1;
                ph_d = ph_q + LN'(k_q);
                if (m_q == LN'(NSAMP - 1))
                begin
                    st_d = dopr_pkg::DOPR_S_BIN;
                end
            end
            dopr_pkg::DOPR_S_BIN:
            begin
                // Strict compare keeps the first bin on a tie
                if (pp > best_d)
                begin
                    best_d = pp;
                    bbin_d = BW'(k_q);
                end
                if (pm > best_d)
                begin
                    best_d = pm;
                    bbin_d = -BW'(k_q);
                end
                if (k_q == KW'(KMAX))
                begin
                    st_d = dopr_pkg::DOPR_S_DEC;
                end
                else
                begin
                    st_d = dopr_pkg::DOPR_S_ACC;
                    k_d = k_q + 1'b1;
                    m_d = '0;
                    ph_d = LN'(k_q + 1'b1); // First sample is m = 1
                    icos_d = '0;
                    isin_d = '0;
                    qcos_d = '0;
                    qsin_d = '0;
                end
            end
            dopr_pkg::DOPR_S_DEC:
            begin
                det_d = (best_q > thresh_i);
                stp_d = !(best_q > thresh_i);
                peak_d = best_q;
                bin_d = bbin_q;
                done_d = 1'b1;
                busy_d = 1'b0;
                st_d = dopr_pkg::DOPR_S_IDLE;
            end
            default:
            begin
                st_d = dopr_pkg::DOPR_S_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end

    // Register the sequencer state
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_q <= dopr_pkg::DOPR_S_IDLE;
            widx_q <= '0;
            k_q <= '0;
            m_q <= '0;
            ph_q <= '0;
            icos_q <= '0;
            isin_q <= '0;
            qcos_q <= '0;
            qsin_q <= '0;
            best_q <= '0;
            bbin_q <= '0;
            det_q <= 1'b0;
            stp_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            peak_q <= '0;
            bin_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            widx_q <= widx_d;
            k_q <= k_d;
            m_q <= m_d;
            ph_q <= ph_d;
            icos_q <= icos_d;
            isin_q <= isin_d;
            qcos_q <= qcos_d;
            qsin_q <= qsin_d;
            best_q <= best_d;
            bbin_q <= bbin_d;
            det_q <= det_d;
            stp_q <= stp_d;
            done_q <= done_d;
            busy_q <= busy_d;
            peak_q <= peak_d;
            bin_q <= bin_d;
        end
    end

    // Outputs straight from flip-flops
    assign smp_ready_o = rdy_q;
    assign busy_o = busy_q;
    assign done_o = done_q;
    assign detect_o = det_q;
    assign step_req_o = stp_q;
    assign bin_o = bin_q;
    assign peak_o = peak_q;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    buf_full_a: assert property (cnt_q == 2'(dopr_pkg::DOPR_BUF_DEPTH)
        |-> !smp_ready_o) else $error("buffer full but ready high");
    fill_len_a: assert property ($rose(st_q == dopr_pkg::DOPR_S_ACC)
        && $past(st_q) == dopr_pkg::DOPR_S_FILL
        |-> $past(widx_q) == LN'(NSAMP - 1))
        else $error("window filled with wrong sample count");
    acc_len_a: assert property (st_q == dopr_pkg::DOPR_S_BIN
        |-> $past(m_q) == LN'(NSAMP - 1))
        else $error("bin summed over wrong sample count");
    all_bins_a: assert property (st_q == dopr_pkg::DOPR_S_DEC
        |-> $past(k_q) == KW'(KMAX))
        else $error("decision before all bins examined");
    peak_mono_a: assert property (st_q == dopr_pkg::DOPR_S_BIN
        |=> best_q >= $past(best_q))
        else $error("peak power decreased");
    detect_thr_a: assert property (done_o
        |-> detect_o == (peak_o > $past(thresh_i)))
        else $error("detect does not match threshold");
    step_excl_a: assert property (done_o
        |-> detect_o != step_req_o ##1 !done_o && !step_req_o)
        else $error("detect and step request not exclusive");
    win_clear_a: assert property ($rose(st_q == dopr_pkg::DOPR_S_FILL)
        |-> best_q == '0 && widx_q == '0 && !detect_o)
        else $error("window start did not clear");
    bin_range_a: assert property (done_o |-> signed'(bin_o) <= BW'(KMAX)
        && signed'(bin_o) >= -BW'(KMAX))
        else $error("bin index out of range");

    detect_c: cover property (done_o && detect_o);
    step_c: cover property (step_req_o);
    stall_c: cover property (smp_valid_i && !smp_ready_o);
    neg_bin_c: cover property (done_o && detect_o && bin_o[BW-1]);

endmodule : dopr_resolver

`default_nettype wire

// ==== verification/dopr_ctrl_model.sv ====
// Behavioural search controller facing the doppler resolver
`timescale 1ns/100ps
`default_nettype none
module dopr_ctrl_model #(
    parameter int GAP = 12,
    parameter int ADV = 8
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic done_i,
    input wire logic detect_i,
    input wire logic dbl_i,
    input wire logic [15:0] noise_i,
    input wire logic [7:0] beta_i,
    output logic step_start_o,
    output logic [dopr_pkg::DOPR_PWR_W-1:0] thresh_o,
    output int phase_o
);
    localparam int PW = dopr_pkg::DOPR_PWR_W;
    int cnt_q;

    // Threshold follows measured noise; beta picks the false alarm rate
    assign thresh_o = PW'(32'(noise_i) * 32'(beta_i));

    // Start GAP cycles after reset or a result; a second start pulse
    // while busy is only sent when the bench asks for it
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_q <= GAP;
            step_start_o <= 1'h0;
            phase_o <= 0;
        end
        else
        begin
            step_start_o <= (cnt_q == 2) || (dbl_i && cnt_q == 1);
            if (done_i)
            begin
                cnt_q <= GAP;
                // Half chip back on a miss, four chips (ADV half chips) ahead on a hit
                phase_o <= detect_i ? phase_o + ADV : phase_o - 1;
            end
            else if (cnt_q > 0)
                cnt_q <= cnt_q - 1;
        end
    end
endmodule : dopr_ctrl_model
`default_nettype wire

// ==== verification/tb_doppler_resolver_dft.sv ====
// Self-checking bench for the doppler resolver with a reference model
`timescale 1ns/100ps
`default_nettype none
module tb_doppler_resolver_dft;
    localparam int PW = dopr_pkg::DOPR_PWR_W;
    logic clk_i = 1'h0;
    logic rstn_i = 1'h1;
    logic step_start_i;
    logic smp_valid_i = 1'h0;
    logic [2:0] smp_i_i = 3'h0;
    logic [2:0] smp_q_i = 3'h0;
    logic [PW-1:0] thresh_i;
    logic smp_ready_o, busy_o, done_o, detect_o, step_req_o;
    logic [3:0] bin_o;
    logic [PW-1:0] peak_o;
    logic dbl = 1'h0;
    logic [15:0] noise = 16'h0000;
    logic [7:0] beta = 8'h01;
    logic [31:0] seed = 32'h17ba;
    int si[16], sq[16];
    int errors = 0, checks_done = 0, eb, ep;
    real ang;

    dopr_resolver DUT (.clk_i(clk_i), .rstn_i(rstn_i),
        .step_start_i(step_start_i), .smp_valid_i(smp_valid_i),
        .smp_i_i(smp_i_i), .smp_q_i(smp_q_i), .smp_ready_o(smp_ready_o),
        .thresh_i(thresh_i), .busy_o(busy_o), .done_o(done_o),
        .detect_o(detect_o), .step_req_o(step_req_o), .bin_o(bin_o),
        .peak_o(peak_o));

    dopr_ctrl_model ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .done_i(done_o),
        .detect_i(detect_o), .dbl_i(dbl), .noise_i(noise), .beta_i(beta),
        .step_start_o(step_start_i), .thresh_o(thresh_i), .phase_o());

    always #50 clk_i = ~clk_i;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Rounded twiddle; sine is the cosine four places back
    function automatic int tw(int i);
        return int'(127.0 * $cos(6.283185307 * (i % 16) / 16.0));
    endfunction : tw

    // Reference: bins 0..KMAX, +k tried before -k, strict greater wins
    task automatic model();
        int ac, bp, bm, c, s, p;
        eb = 0;
        ep = 0;
        for (int k = 0; k <= dopr_pkg::DOPR_KMAX; k++)
        begin
            ac = 0;
            bp = 0;
            bm = 0;
            for (int n = 0; n < 16; n++)
            begin
                c = tw(k * (n + 1));
                s = tw(k * (n + 1) + 12);
                ac += si[n] * c + sq[n] * s;
                bp += sq[n] * c + si[n] * s;
                bm += sq[n] * c - si[n] * s;
            end
            ac = ac >>> 5;
            bp = bp >>> 5;
            bm = bm >>> 5;
            p = ac * ac + bp * bp;
            if (p > ep) eb = k;
            ep = (p > ep) ? p : ep;
            p = ac * ac + bm * bm;
            if (p > ep) eb = -k;
            ep = (p > ep) ? p : ep;
        end
    endtask : model

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (!ok)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    // One window of samples with random gaps; early pairs wait in buffer
    task automatic push();
        for (int n = 0; n < 16; n++)
        begin
            smp_valid_i <= 1'h1;
            smp_i_i <= 3'(si[n]);
            smp_q_i <= 3'(sq[n]);
            do @(posedge clk_i); while (smp_ready_o !== 1'h1);
            if (n == 1 && busy_o !== 1'h1)
            begin
                smp_valid_i <= 1'h0;
                repeat (2) @(posedge clk_i);
                if (busy_o !== 1'h1) chk(smp_ready_o === 1'h0, "ready");
            end
            else if (xs() % 4 == 0)
            begin
                smp_valid_i <= 1'h0;
                @(posedge clk_i);
            end
        end
        smp_valid_i <= 1'h0;
    endtask : push

    // Wait for start and result, then compare with the reference
    task automatic result();
        int thr;
        do @(posedge clk_i); while (busy_o !== 1'h1);
        chk(detect_o === 1'h0, "detect kept");
        do @(posedge clk_i); while (done_o !== 1'h1);
        model();
        thr = int'(noise) * int'(beta);
        chk(peak_o === PW'(ep), "peak");
        chk(bin_o === 4'(eb), "bin");
        chk(detect_o === 1'(ep > thr), "detect");
        chk(step_req_o === 1'(ep <= thr), "step request");
    endtask : result

    task automatic run();
        fork
            push();
            result();
        join
    endtask : run

    task automatic conclude();
        $display("checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // Reset, silence, a tone in every bin, then random noise windows
    initial
    begin
        rstn_i = 1'h0;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'h1;
        chk({smp_ready_o, busy_o, done_o, detect_o, step_req_o} === 5'h10
            && bin_o === 4'h0 && peak_o === '0, "reset");
        for (int n = 0; n < 16; n++)
        begin
            si[n] = 0;
            sq[n] = 0;
        end
        run();
        noise <= 16'h0032;
        beta <= 8'h04;
        for (int k = -4; k <= 4; k++)
        begin
            for (int n = 0; n < 16; n++)
            begin
                ang = 6.283185307 * k * (n + 1) / 16.0;
                si[n] = int'(3.0 * (k < 0 ? $sin(ang) : $cos(ang)));
                sq[n] = int'(3.0 * (k < 0 ? $cos(ang) : $sin(ang)));
            end
            run();
        end
        for (int w = 0; w < 6; w++)
        begin
            for (int n = 0; n < 16; n++)
            begin
                si[n] = int'($signed(3'(xs())));
                sq[n] = int'($signed(3'(xs())));
            end
            noise <= 16'(xs() % 2000);
            beta <= 8'(1 + xs() % 8);
            dbl <= 1'(w == 3);
            run();
        end
        conclude();
    end

    // Watchdog: about six times the expected run
    initial
    begin
        repeat (12000) @(posedge clk_i);
        errors++;
        conclude();
    end
endmodule : tb_doppler_resolver_dft
`default_nettype wire
